// file: async_serial_port_txrx.v
// Purpose: Asynchronous serial port (transmitter, receiver, baud generator)
//          with an Avalon-MM register slave.
// Assumes: i_mclk is the oscillator; one instruction cycle is four clocks.
//          Pin inputs are synchronous to i_mclk.
// Notes:   Synchronous master mode only claims the transmit pin; no clocked transfers.
// Behaviour
// - Synchronous-select clear selects asynchronous mode
// - Start bit, eight or nine data, stop
// - Data shifted least significant bit first
// - Independent paths sharing format and baud rate
// - Eight-bit divisor gives x16 or x64 clock
// - No hardware parity; ninth bit carries it
// - Shifter reloads only after stop bit sent
// - Buffer-empty flag set by hardware; software cannot clear
// - Buffer-empty flag clears two cycles after write
// - Read-only shifter-empty bit, no interrupt
// - Transmit shifter is not software addressable
// - Setting transmit enable sets buffer-empty flag
// - Buffer write with enables starts transmission
// - Receiver samples at sixteen times baud
// - Continuous-receive enable turns reception on
// - Receive-complete flag; request only when enabled
// - Clearing continuous receive clears errors
// - Address detect off passes every word
// - Clock-source plus sync selects half-duplex master
// - Port enable turns pins into clock/data
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_consts.vh"

module async_serial_port_txrx (
   // Clock and reset.
   input  wire        i_mclk,
   input  wire        i_rst_b,
   // Avalon-MM slave.
   input  wire [4:0]  i_avs_address,
   input  wire        i_avs_read,
   input  wire        i_avs_write,
   input  wire [31:0] i_avs_writedata,
   input  wire [3:0]  i_avs_byteenable,
   output reg  [31:0] o_avs_readdata,
   output reg         o_avs_waitrequest,
   // Serial pins.
   input  wire        i_receive_pin,
   output reg         o_transmit_pin,
   output reg         o_transmit_pin_oe,
   output reg         o_sync_data_line_out,
   output reg         o_sync_data_line_oe,
   // Interrupt requests to the system.
   output reg         o_transmit_irq,
   output reg         o_receive_irq
);

   // Receiver states, one-hot.
   localparam [3:0] RX_IDLE  = 4'h1;
   localparam [3:0] RX_START = 4'h2;
   localparam [3:0] RX_DATA  = 4'h4;
   localparam [3:0] RX_STOP  = 4'h8;

   // Software-visible control state.
   reg [7:0]  transmit_status_control;
   reg [7:0]  receive_status_control;
   reg [7:0]  baud_divisor;
   reg [7:0]  transmit_buffer;
   reg [7:0]  receive_buffer;
   reg [1:0]  peripheral_enable_group3;
   reg [1:0]  peripheral_priority_group3;
   reg        transmit_buffer_empty_flag;
   reg        receive_complete_flag;
   reg        framing_error;
   reg        overrun_error;
   reg        ninth_receive_bit;

   // Internal state.
   reg [1:0]  tcy_cnt;
   reg        tcy_tick;
   reg [7:0]  brg_cnt;
   reg [1:0]  pre_cnt;
   reg        sample_tick;
   reg        buffer_full;
   reg        buffer_ninth;
   reg [1:0]  flag_delay;
   reg [10:0] transmit_shifter;
   reg [3:0]  tx_bits;
   reg [3:0]  tx_sub;
   reg        tx_busy;
   reg        tx_line;
   reg [3:0]  rx_state;
   reg [3:0]  rx_sub;
   reg [3:0]  rx_bits;
   reg [8:0]  rx_shift;
   reg        rx_prev;

   // Field aliases and decoded modes.
   wire serial_port_enable       = receive_status_control[`BIT_SERIAL_PORT_ENABLE];
   wire nine_bit_receive_enable  = receive_status_control[`BIT_RX9];
   wire continuous_receive_enable = receive_status_control[`BIT_CONTINUOUS_RECEIVE_ENABLE];
   wire address_detect_enable    = receive_status_control[`BIT_ADDRESS_DETECT_ENABLE];
   wire clock_source_select      = transmit_status_control[`BIT_CLOCK_SOURCE_SELECT];
   wire nine_bit_transmit_enable = transmit_status_control[`BIT_TX9];
   wire transmit_enable          = transmit_status_control[`BIT_TRANSMIT_ENABLE];
   wire sync_select              = transmit_status_control[`BIT_SYNC];
   wire high_speed_baud_select   = transmit_status_control[`BIT_HIGH_SPEED_BAUD_SELECT];
   wire async_on = serial_port_enable & ~sync_select;
   wire sync_master = serial_port_enable & sync_select & clock_source_select;

   // Bus access decode: an access completes at the edge where waitrequest is low.
   wire bus_go   = ~o_avs_waitrequest;
   wire wr_go    = bus_go & i_avs_write & i_avs_byteenable[0];
   wire rd_go    = bus_go & i_avs_read;
   wire wr_txbuf = wr_go & (i_avs_address == `OFS_TXBUF);
   wire wr_txsta = wr_go & (i_avs_address == `OFS_TXSTA);
   wire wr_rcsta = wr_go & (i_avs_address == `OFS_RCSTA);
   wire rd_rxbuf = rd_go & (i_avs_address == `OFS_RXBUF);
   wire [7:0] wd = i_avs_writedata[7:0];

   // Receive completion and transmit load decode.
   wire rx_done  = (rx_state == RX_STOP) & sample_tick & (rx_sub == `SAMPLE_MID);
   wire rx_ninth = nine_bit_receive_enable ? rx_shift[8] : 1'b0;
   wire rx_keep  = ~(nine_bit_receive_enable & address_detect_enable) | rx_ninth;
   wire tx_load  = tcy_tick & ~tx_busy & buffer_full & transmit_enable & async_on;

   // Read multiplexer; the transmit shifter has no address.
   reg [7:0] rd_mux;
   always @*
   begin
      rd_mux = `RST_BYTE;
      case (i_avs_address)
         `OFS_FLAG:
         begin
            rd_mux[`BIT_RX_FLAG] = receive_complete_flag;
            rd_mux[`BIT_TX_FLAG] = transmit_buffer_empty_flag;
         end
         `OFS_ENABLE:   rd_mux[5:4] = peripheral_enable_group3;
         `OFS_PRIORITY: rd_mux[5:4] = peripheral_priority_group3;
         `OFS_RCSTA:
         begin
            rd_mux = receive_status_control;
            rd_mux[`BIT_FRAMING_ERROR] = framing_error;
            rd_mux[`BIT_OVERRUN_ERROR] = overrun_error;
            rd_mux[`BIT_NINTH_RECEIVE_BIT] = ninth_receive_bit;
         end
         `OFS_TXBUF:    rd_mux = transmit_buffer;
         `OFS_TXSTA:
         begin
            rd_mux = transmit_status_control;
            rd_mux[3] = 1'b0;
            rd_mux[`BIT_SHIFTER_EMPTY] = ~tx_busy;
         end
         `OFS_BAUD:     rd_mux = baud_divisor;
         `OFS_RXBUF:    rd_mux = receive_buffer;
         default:       rd_mux = `RST_BYTE;
      endcase
   end

   // Avalon slave handshake: one wait cycle, then completion with data.
   always @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata    <= 32'h00000000;
      end
      else if (o_avs_waitrequest && (i_avs_read || i_avs_write))
      begin
         o_avs_waitrequest <= 1'b0;
         o_avs_readdata    <= {24'h000000, rd_mux};
      end
      else
      begin
         o_avs_waitrequest <= 1'b1;
      end
   end

   // Instruction-cycle enable: one pulse every four clocks.
   always @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         tcy_cnt  <= 2'h0;
         tcy_tick <= 1'b0;
      end
      else
      begin
         tcy_cnt  <= tcy_cnt + 2'h1;
         tcy_tick <= (tcy_cnt == `TCY_CLOCKS);
      end
   end

   // Shared baud generator; without high speed, x64 pulses are divided by four to the x16 sample rate.
   always @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         brg_cnt     <= `RST_BYTE;
         pre_cnt     <= 2'h0;
         sample_tick <= 1'b0;
      end
      else if (brg_cnt == 8'h00)
      begin
         brg_cnt     <= baud_divisor;
         pre_cnt     <= pre_cnt + 2'h1;
         sample_tick <= high_speed_baud_select | (pre_cnt == `SLOW_PRESCALE);
      end
      else
      begin
         brg_cnt     <= brg_cnt - 8'h01;
         sample_tick <= 1'b0;
      end
   end

   // Control registers written by software.
   always @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         transmit_status_control    <= `RST_BYTE;
         receive_status_control     <= `RST_BYTE;
         baud_divisor               <= `RST_BYTE;
         peripheral_enable_group3   <= 2'h0;
         peripheral_priority_group3 <= 2'h0;
      end
      else if (wr_go)
      begin
         case (i_avs_address)
            `OFS_TXSTA:    transmit_status_control <= {wd[7:4], 1'b0, wd[2], 1'b0, wd[0]};
            `OFS_RCSTA:    receive_status_control  <= {wd[7:3], 3'h0};
            `OFS_BAUD:     baud_divisor <= wd;
            `OFS_ENABLE:   peripheral_enable_group3 <= wd[5:4];
            `OFS_PRIORITY: peripheral_priority_group3 <= wd[5:4];
            default:       baud_divisor <= baud_divisor;
         endcase
      end
   end

   // Transmit buffer and its empty flag; hardware set wins over any clear.
   always @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         transmit_buffer            <= `RST_BYTE;
         buffer_full                <= 1'b0;
         buffer_ninth               <= 1'b0;
         flag_delay                 <= 2'h0;
         transmit_buffer_empty_flag <= 1'b0;
      end
      else
      begin
         if (wr_txbuf)
         begin
            transmit_buffer <= wd;
            buffer_ninth    <= transmit_status_control[`BIT_NINTH_TRANSMIT_BIT];
            buffer_full     <= 1'b1;
            flag_delay      <= 2'h2;
         end
         else if (tx_load)
         begin
            buffer_full <= 1'b0;
         end
         if (tx_load || (wr_txsta && wd[`BIT_TRANSMIT_ENABLE] && !transmit_enable))
         begin
            transmit_buffer_empty_flag <= 1'b1;
         end
         else if (tcy_tick && flag_delay != 2'h0)
         begin
            flag_delay <= flag_delay - 2'h1;
            if (flag_delay == 2'h1)
            begin
               transmit_buffer_empty_flag <= ~buffer_full;
            end
         end
      end
   end

   // Transmit shifter: start low, data LSB first, optional ninth, stop high.
   always @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         transmit_shifter <= 11'h7FF;
         tx_bits          <= 4'h0;
         tx_sub           <= 4'h0;
         tx_busy          <= 1'b0;
         tx_line          <= 1'b1;
      end
      else if (!transmit_enable || !async_on)
      begin
         tx_busy <= 1'b0;
         tx_line <= 1'b1;
      end
      else if (tx_load)
      begin
         transmit_shifter <= {1'b1, nine_bit_transmit_enable ? buffer_ninth : 1'b1,
                              transmit_buffer, 1'b0};
         tx_bits <= nine_bit_transmit_enable ? `FRAME9_BITS : `FRAME8_BITS;
         tx_sub  <= 4'h0;
         tx_busy <= 1'b1;
      end
      else if (tx_busy && sample_tick)
      begin
         if (tx_sub == 4'h0)
         begin
            tx_line <= transmit_shifter[0];
         end
         tx_sub <= tx_sub + 4'h1;
         if (tx_sub == `SAMPLE_LAST)
         begin
            transmit_shifter <= {1'b1, transmit_shifter[10:1]};
            tx_bits <= tx_bits - 4'h1;
            tx_busy <= (tx_bits != 4'h1);
         end
      end
   end

   // Receiver: falling edge of start, mid-bit samples at the x16 rate.
   always @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         rx_state <= RX_IDLE;
         rx_sub   <= 4'h0;
         rx_bits  <= 4'h0;
         rx_shift <= 9'h000;
         rx_prev  <= 1'b1;
      end
      else if (!async_on || !continuous_receive_enable)
      begin
         rx_state <= RX_IDLE;
         rx_prev  <= 1'b1;
      end
      else
      begin
         if (sample_tick)
         begin
            rx_prev <= i_receive_pin;
            rx_sub  <= rx_sub + 4'h1;
         end
         case (rx_state)
            RX_IDLE:
            begin
               if (sample_tick && rx_prev && !i_receive_pin)
               begin
                  rx_state <= RX_START;
                  rx_sub   <= 4'h1;
               end
            end
            RX_START:
            begin
               if (sample_tick && rx_sub == `SAMPLE_MID)
               begin
                  rx_state <= i_receive_pin ? RX_IDLE : RX_DATA;
                  rx_bits  <= nine_bit_receive_enable ? `DATA9_BITS : `DATA8_BITS;
               end
            end
            RX_DATA:
            begin
               if (sample_tick && rx_sub == `SAMPLE_MID)
               begin
                  rx_shift <= nine_bit_receive_enable ?
                              {i_receive_pin, rx_shift[8:1]} :
                              {1'b0, i_receive_pin, rx_shift[7:1]};
                  rx_bits  <= rx_bits - 4'h1;
                  if (rx_bits == 4'h1)
                  begin
                     rx_state <= RX_STOP;
                  end
               end
            end
            RX_STOP:
            begin
               if (rx_done)
               begin
                  rx_state <= RX_IDLE;
               end
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end

   // Receive buffer, completion flag and errors; a new word wins over a read or an error clear.
   always @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         receive_buffer        <= `RST_BYTE;
         receive_complete_flag <= 1'b0;
         framing_error         <= 1'b0;
         overrun_error         <= 1'b0;
         ninth_receive_bit     <= 1'b0;
      end
      else
      begin
         if (wr_rcsta && !wd[`BIT_CONTINUOUS_RECEIVE_ENABLE])
         begin
            overrun_error <= 1'b0;
            framing_error <= 1'b0;
         end
         if (rx_done && rx_keep && continuous_receive_enable)
         begin
            if (receive_complete_flag && !rd_rxbuf)
            begin
               overrun_error <= 1'b1;
            end
            else
            begin
               receive_buffer        <= rx_shift[7:0];
               ninth_receive_bit     <= rx_ninth;
               framing_error         <= ~i_receive_pin;
               receive_complete_flag <= 1'b1;
            end
         end
         else if (rd_rxbuf)
         begin
            receive_complete_flag <= 1'b0;
         end
      end
   end

   // Pins and interrupt requests, all registered.
   always @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         o_transmit_pin       <= 1'b1;
         o_transmit_pin_oe    <= 1'b0;
         o_sync_data_line_out <= 1'b1;
         o_sync_data_line_oe  <= 1'b0;
         o_transmit_irq       <= 1'b0;
         o_receive_irq        <= 1'b0;
      end
      else
      begin
         o_transmit_pin       <= async_on ? tx_line : 1'b1;
         o_transmit_pin_oe    <= async_on | sync_master;
         o_sync_data_line_out <= 1'b1;
         o_sync_data_line_oe  <= 1'b0;
         o_transmit_irq <= transmit_buffer_empty_flag & peripheral_enable_group3[0];
         o_receive_irq  <= receive_complete_flag & peripheral_enable_group3[1];
      end
   end

endmodule // async_serial_port_txrx
`default_nettype wire

// file: serial_port_consts.vh
// Purpose: Constants for the asynchronous serial port block.
// Assumes: Byte addressing on a 32-bit Avalon-MM slave, one word per register.
// Notes:   Offsets, field positions, reset values and timing counts only.
`ifndef SERIAL_PORT_CONSTS_VH
`define SERIAL_PORT_CONSTS_VH

// Register byte offsets.
`define OFS_FLAG      5'h00
`define OFS_ENABLE    5'h04
`define OFS_PRIORITY  5'h08
`define OFS_RCSTA     5'h0C
`define OFS_TXBUF     5'h10
`define OFS_TXSTA     5'h14
`define OFS_BAUD      5'h18
`define OFS_RXBUF     5'h1C

// Flag, enable and priority register fields.
`define BIT_RX_FLAG   5
`define BIT_TX_FLAG   4

// Transmit status/control fields.
`define BIT_CLOCK_SOURCE_SELECT      7
`define BIT_TX9       6
`define BIT_TRANSMIT_ENABLE      5
`define BIT_SYNC      4
`define BIT_HIGH_SPEED_BAUD_SELECT      2
`define BIT_SHIFTER_EMPTY      1
`define BIT_NINTH_TRANSMIT_BIT      0

// Receive status/control fields.
`define BIT_SERIAL_PORT_ENABLE      7
`define BIT_RX9       6
`define BIT_SINGLE_RECEIVE_ENABLE      5
`define BIT_CONTINUOUS_RECEIVE_ENABLE      4
`define BIT_ADDRESS_DETECT_ENABLE     3
`define BIT_FRAMING_ERROR      2
`define BIT_OVERRUN_ERROR      1
`define BIT_NINTH_RECEIVE_BIT      0

// Reset values.
`define RST_BYTE      8'h00

// Timing: system clocks per instruction cycle, samples per bit.
`define TCY_CLOCKS    2'h3
`define SLOW_PRESCALE 2'h3
`define SAMPLE_LAST   4'hF
`define SAMPLE_MID    4'h7
`define FRAME8_BITS   4'hA
`define FRAME9_BITS   4'hB
`define DATA8_BITS    4'h8
`define DATA9_BITS    4'h9

`endif

// file: serial_port_chk_sva.sv
// Purpose: Port-level assertions for the serial port block.
// Assumes: Bit times of sixteen clocks or more.
// Notes:   Bound to the design from tb_top.
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_consts.vh"

module serial_port_chk (
   // Clock, reset and register bus.
   input wire logic        i_mclk,
   input wire logic        i_rst_b,
   input wire logic [4:0]  i_avs_address,
   input wire logic        i_avs_read,
   input wire logic        i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0]  i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic        o_avs_waitrequest,
   // Pin and requests.
   input wire logic        o_transmit_pin,
   input wire logic        o_transmit_pin_oe,
   input wire logic        o_transmit_irq,
   input wire logic        o_receive_irq
);
   // A completed write to the enable register.
   wire ena_wr = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0]
      & (i_avs_address == `OFS_ENABLE);

   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);

   rst_idle_a: assert property (disable iff (1'b0) !i_rst_b |=> o_transmit_pin
      && !o_transmit_pin_oe && !o_transmit_irq && !o_receive_irq && o_avs_waitrequest)
      else $error("outputs not idle after reset");
   start_len_a: assert property ($fell(o_transmit_pin) |-> !o_transmit_pin[*8])
      else $error("low bit shorter than eight clocks");
   bit_len_a: assert property ($rose(o_transmit_pin) |-> o_transmit_pin[*8])
      else $error("high bit shorter than eight clocks");
   off_idle_a: assert property (!o_transmit_pin_oe |-> o_transmit_pin)
      else $error("undriven transmit pin not high");
   tx_mask_a: assert property (ena_wr && !i_avs_writedata[4] |-> ##2 !o_transmit_irq)
      else $error("transmit request while masked");
   rx_mask_a: assert property (ena_wr && !i_avs_writedata[5] |-> ##2 !o_receive_irq)
      else $error("receive request while masked");
   hidden_reg_a: assert property (i_avs_read && !o_avs_waitrequest
      && i_avs_address[1:0] != 2'h0 |-> o_avs_readdata == 32'h00000000)
      else $error("unmapped read not zero");
   wait_one_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> !o_avs_waitrequest) else $error("no answer one cycle after request");
   wait_rel_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low for two cycles");
   high_zero_a: assert property (!o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");

   // Main scenarios reached.
   cover property ($fell(o_transmit_pin));
   cover property ($rose(o_receive_irq));
   cover property ($rose(o_transmit_irq));
endmodule // serial_port_chk
`default_nettype wire

// file: serial_node.sv
// Purpose: Remote serial node facing the port's pins.
// Assumes: Bit time given in clocks by the bench.
// Notes:   Idle line held high, as by a pull-up.
`timescale 1ns/1ps
`default_nettype none

module serial_node (
   // Clock and format.
   input  wire logic       i_mclk,
   input  wire logic [7:0] i_bit_clks,
   input  wire logic       i_nine,
   // Serial lines.
   input  wire logic       i_line_in,
   output var  logic       o_line_out
);
   logic [9:0] rx_q[$];

   initial o_line_out = 1'b1;

   // Sends start, data lowest bit first, optional ninth bit, stop.
   task automatic send(input logic [8:0] v, input logic stop, input int gap);
      logic [11:0] f;
      f = i_nine ? {1'b1, stop, v, 1'b0} : {2'h3, stop, v[7:0], 1'b0};
      repeat (gap) @(posedge i_mclk);
      repeat (i_nine ? 11 : 10)
      begin
         o_line_out <= f[0];
         f = f >> 1;
         repeat (i_bit_clks) @(posedge i_mclk);
      end
      o_line_out <= 1'b1;
   endtask

   // Samples each device frame mid-bit from the start edge; queues stop and data.
   always
   begin : catch
      logic [8:0] w;
      int k;
      @(negedge i_line_in);
      w = 9'h000;
      repeat (i_bit_clks / 2) @(posedge i_mclk);
      for (k = 0; k < (i_nine ? 9 : 8); k++)
      begin
         repeat (i_bit_clks) @(posedge i_mclk);
         w[k] = i_line_in;
      end
      repeat (i_bit_clks) @(posedge i_mclk);
      rx_q.push_back({i_line_in, w});
   end
endmodule // serial_node
`default_nettype wire

// file: tb_top.sv
// Purpose: Self-checking bench for the serial port block.
// Assumes: Divisor 0, so a bit is 16 clocks, or 64 with slow select.
// Notes:   Random data from a fixed seed.
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_consts.vh"

module tb_top;
   logic        i_mclk;
   logic        i_rst_b;
   logic [4:0]  i_avs_address;
   logic        i_avs_read;
   logic        i_avs_write;
   logic [31:0] i_avs_writedata;
   logic [3:0]  be;
   logic [31:0] o_avs_readdata;
   logic        o_avs_waitrequest;
   logic        rx_line;
   logic        tx_line;
   logic        tx_oe;
   logic        tx_irq;
   logic        rx_irq;
   logic        sd_out;
   logic        sd_oe;
   logic [7:0]  bit_clks;
   logic        nine;
   logic [7:0]  q;
   logic [7:0]  d;
   logic [7:0]  d2;
   int          err_total;
   int          check_count;
   int          n;

   async_serial_port_txrx i_async_serial_port_txrx (
      .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_avs_address(i_avs_address),
      .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
      .i_avs_byteenable(be), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest), .i_receive_pin(rx_line),
      .o_transmit_pin(tx_line), .o_transmit_pin_oe(tx_oe), .o_sync_data_line_out(sd_out),
      .o_sync_data_line_oe(sd_oe), .o_transmit_irq(tx_irq), .o_receive_irq(rx_irq));

   serial_node i_serial_node (
      .i_mclk(i_mclk), .i_bit_clks(bit_clks), .i_nine(nine),
      .i_line_in(tx_line), .o_line_out(rx_line));

   // Free-running 25 MHz clock.
   initial
   begin
      i_mclk = 1'b0;
      forever #20 i_mclk = ~i_mclk;
   end

   // One bus access; holds the request until waitrequest is seen low.
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v);
      @(posedge i_mclk);
      i_avs_address <= a;
      i_avs_write <= w;
      i_avs_read <= ~w;
      i_avs_writedata <= {24'h000000, v};
      n = 0;
      do
      begin
         @(posedge i_mclk);
         n++;
      end
      while (o_avs_waitrequest !== 1'b0 && n < 40);
      if (n >= 40) report_and_stop(1);
      q = o_avs_readdata[7:0];
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
   endtask

   task automatic check(input logic [9:0] got, input logic [9:0] exp);
      check_count++;
      if (got !== exp)
         err_total++;
      if (got !== exp)
         $display("Error at %0t: saw %h, wanted %h", $time, got, exp);
   endtask

   task automatic rchk(input logic [4:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      check({2'h0, q}, {2'h0, e});
   endtask

   // Expected frame as captured: stop high, then data in the current format.
   function automatic logic [9:0] frame(input logic [8:0] v);
      return {1'b1, nine ? v : {1'b0, v[7:0]}};
   endfunction

   // Waits, bounded, for the node to catch one frame, then lets the stop bit end.
   task automatic txget(input logic [8:0] v);
      n = 0;
      while (i_serial_node.rx_q.size() == 0 && n < 3000)
      begin
         @(posedge i_mclk);
         n++;
      end
      if (n >= 3000) report_and_stop(1);
      check(i_serial_node.rx_q.pop_front(), frame(v));
      repeat (bit_clks) @(posedge i_mclk);
   endtask

   task automatic report_and_stop(input int extra);
      err_total += extra;
      $display("Checks %0d, mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Main sequence.
   initial
   begin
      i_rst_b = 1'b0;
      i_avs_address = 5'h00;
      i_avs_read = 1'b0;
      i_avs_write = 1'b0;
      i_avs_writedata = 32'h00000000;
      be = 4'hF;
      bit_clks = 8'h10;
      nine = 1'b0;
      err_total = 0;
      check_count = 0;
      void'($urandom(42173));
      repeat (5) @(posedge i_mclk);
      i_rst_b <= 1'b1;
      rchk(`OFS_ENABLE, `RST_BYTE);
      rchk(`OFS_RCSTA, `RST_BYTE);
      rchk(5'h05, 8'h00);
      d = $urandom;
      bus(1'b1, `OFS_ENABLE, d);
      rchk(`OFS_ENABLE, d & 8'h30);
      bus(1'b1, `OFS_PRIORITY, ~d);
      rchk(`OFS_PRIORITY, ~d & 8'h30);
      bus(1'b1, `OFS_BAUD, d);
      be <= 4'h0;
      bus(1'b1, `OFS_BAUD, ~d);
      be <= 4'hF;
      rchk(`OFS_BAUD, d);
      bus(1'b1, `OFS_FLAG, 8'hFF);
      rchk(`OFS_FLAG, 8'h00);
      $display("Register test done");
      bus(1'b1, `OFS_BAUD, 8'h00);
      bus(1'b1, `OFS_ENABLE, 8'h00);
      bus(1'b1, `OFS_RCSTA, 8'h90);
      bus(1'b1, `OFS_TXSTA, 8'h24);
      rchk(`OFS_FLAG, 8'h10);
      check(tx_oe, 1'b1);
      bus(1'b1, `OFS_FLAG, 8'h00);
      rchk(`OFS_FLAG, 8'h10);
      bus(1'b1, `OFS_ENABLE, 8'h10);
      d = $urandom;
      d2 = $urandom;
      bus(1'b1, `OFS_TXBUF, d);
      repeat (12) @(posedge i_mclk);
      rchk(`OFS_FLAG, 8'h10);
      rchk(`OFS_TXSTA, 8'h24);
      bus(1'b1, `OFS_TXBUF, d2);
      repeat (12) @(posedge i_mclk);
      rchk(`OFS_FLAG, 8'h00);
      check(tx_irq, 1'b0);
      txget({1'b0, d});
      check(tx_irq, 1'b1);
      txget({1'b0, d2});
      rchk(`OFS_TXSTA, 8'h26);
      nine = 1'b1;
      bus(1'b1, `OFS_TXSTA, {7'h32, d2[0]});
      bus(1'b1, `OFS_TXBUF, d);
      txget({d2[0], d});
      nine = 1'b0;
      bit_clks = 8'h40;
      bus(1'b1, `OFS_TXSTA, 8'h20);
      bus(1'b1, `OFS_TXBUF, d2);
      txget({1'b0, d2});
      bit_clks = 8'h10;
      bus(1'b1, `OFS_TXSTA, 8'h24);
      $display("Transmit test done");
      bus(1'b1, `OFS_ENABLE, 8'h20);
      d = $urandom;
      i_serial_node.send({1'b0, d}, 1'b1, $urandom_range(0, 40));
      rchk(`OFS_FLAG, 8'h30);
      check(rx_irq, 1'b1);
      rchk(`OFS_RCSTA, 8'h90);
      rchk(`OFS_RXBUF, d);
      rchk(`OFS_FLAG, 8'h10);
      i_serial_node.send({1'b0, d}, 1'b1, 2);
      i_serial_node.send({1'b0, d2}, 1'b1, 2);
      rchk(`OFS_RCSTA, 8'h92);
      bus(1'b1, `OFS_RCSTA, 8'h80);
      rchk(`OFS_RCSTA, 8'h80);
      rchk(`OFS_RXBUF, d);
      i_serial_node.send({1'b0, d2}, 1'b1, 2);
      rchk(`OFS_FLAG, 8'h10);
      bus(1'b1, `OFS_RCSTA, 8'h90);
      i_serial_node.send({1'b0, d2}, 1'b0, 5);
      rchk(`OFS_RCSTA, 8'h94);
      bus(1'b1, `OFS_RCSTA, 8'h80);
      rchk(`OFS_RCSTA, 8'h80);
      bus(1'b0, `OFS_RXBUF, 8'h00);
      $display("Receive test done");
      nine = 1'b1;
      bus(1'b1, `OFS_RCSTA, 8'hD8);
      i_serial_node.send({1'b0, d}, 1'b1, 3);
      rchk(`OFS_FLAG, 8'h10);
      i_serial_node.send({1'b1, d2}, 1'b1, 3);
      rchk(`OFS_RCSTA, 8'hD9);
      rchk(`OFS_RXBUF, d2);
      bus(1'b1, `OFS_RCSTA, 8'hD0);
      i_serial_node.send({1'b0, d}, 1'b1, 3);
      rchk(`OFS_RCSTA, 8'hD0);
      rchk(`OFS_RXBUF, d);
      $display("Address test done");
      bus(1'b1, `OFS_TXSTA, 8'h30);
      bus(1'b1, `OFS_TXBUF, d);
      repeat (40) @(posedge i_mclk);
      check(tx_oe, 1'b0);
      rchk(`OFS_TXSTA, 8'h32);
      check({9'h000, i_serial_node.rx_q.size() == 0}, 10'h001);
      bus(1'b1, `OFS_TXSTA, 8'hB0);
      rchk(`OFS_TXSTA, 8'hB2);
      check({tx_oe, tx_line}, 2'h3);
      check({sd_out, sd_oe}, 2'h2);
      $display("Sync mode test done");
      report_and_stop(0);
   end
endmodule // tb_top

bind async_serial_port_txrx serial_port_chk i_serial_port_chk (
   .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
   .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest), .o_transmit_pin(o_transmit_pin),
   .o_transmit_pin_oe(o_transmit_pin_oe), .o_transmit_irq(o_transmit_irq),
   .o_receive_irq(o_receive_irq));
`default_nettype wire
